// >>> common/pmofsm_pkg.sv
package pmofsm_pkg;

    // Register map
    localparam logic [7:0] PWRCTL_ADDR = 8'h1B;
    localparam logic [7:0] STATUS_ADDR = 8'h1C;
    localparam logic [7:0] ONSP_ADDR = 8'h20;
    localparam logic [7:0] STBYSP_ADDR = 8'h28;
    localparam logic [7:0] SLPSP_ADDR = 8'h30;

    // Power control fields
    localparam int STANDBY_POLARITY_INVERT_BIT = 6;
    localparam int STANDBY_HOLD_OFF_DELAY_LSB = 4;
    localparam int STANDBY_HOLD_OFF_DELAY_MSB = 5;
    localparam logic [1:0] STANDBY_HOLD_OFF_DELAY_RST = 2'h1;
    localparam logic STANDBY_POLARITY_INVERT_RST = 1'h0;

    // Set point reset values
    localparam logic [7:0] ONSP_RST = 8'h10;
    localparam logic [7:0] SLPSP_RST = 8'h08;

    localparam int NUM_BUCK = 3;

    // Timing
    localparam int CLK_FREQ_HZ = 250_000_000;
    localparam int SLOW_FREQ_HZ = 32_768;
    localparam int TICK_DIV = CLK_FREQ_HZ / SLOW_FREQ_HZ;
    localparam int TICK_W = 13;
    localparam int LONG_PRESS_MS = 4000;
    localparam int LONG_PRESS_TICKS = (LONG_PRESS_MS * SLOW_FREQ_HZ) / 1000;
    localparam int LONG_W = 18;
    localparam int STANDBY_REQUEST_PIN_SYNC_TICKS = 3;

    typedef enum logic [2:0] {
        ST_COIN,
        ST_OFF,
        ST_ON,
        ST_STANDBY_REQUEST_PIN,
        ST_SLEEP
    } pmofsm_state_e;

    typedef struct packed {
        logic en;
        logic pfm;
        logic [7:0] vsel;
    } pmofsm_rail_s;

    typedef struct packed {
        logic en_cfg;
        logic long_press_off_enable;
        logic auto_restart_enable;
        logic [NUM_BUCK-1:0] regulator_sleep_mode_bit;
        logic linear1_sleep_mode_bit;
        logic linear3_sleep_mode_bit;
    } pmofsm_cfg_s;

endpackage : pmofsm_pkg

// >>> hw/pmofsm_standby_request_pin_qual.sv
`timescale 1ns/100ps
module pmofsm_standby_request_pin_qual (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic tick_in,
    input wire logic pin_in,
    input wire logic invert_in,
    input wire logic [1:0] delay_in,
    output logic standby_request_pin_ctl_out
);
    logic [pmofsm_pkg::STANDBY_REQUEST_PIN_SYNC_TICKS-1:0] shift_reg;
    logic [1:0] dly_cnt_reg;
    logic raw;

    assign raw = pin_in ^ invert_in;

    // Three slow-clock stages before the event is seen
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_reg <= '0;
        end else if (tick_in) begin
            shift_reg <= {shift_reg[pmofsm_pkg::STANDBY_REQUEST_PIN_SYNC_TICKS-2:0], raw};
        end
    end

    // Hold-off applies to entry only; exit is not delayed
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dly_cnt_reg <= 2'h0;
            standby_request_pin_ctl_out <= 1'b0;
        end else if (!shift_reg[pmofsm_pkg::STANDBY_REQUEST_PIN_SYNC_TICKS-1]) begin
            dly_cnt_reg <= 2'h0;
            standby_request_pin_ctl_out <= 1'b0;
        end else if (!standby_request_pin_ctl_out) begin
            if (dly_cnt_reg == delay_in) begin
                standby_request_pin_ctl_out <= 1'b1;
            end else if (tick_in) begin
                dly_cnt_reg <= dly_cnt_reg + 2'h1;
            end
        end
    end
endmodule : pmofsm_standby_request_pin_qual

// >>> hw/pmofsm_top.sv
`timescale 1ns/100ps
module pmofsm_top #(
    parameter int TICK_DIV_P = pmofsm_pkg::TICK_DIV,
    parameter int LONG_TICKS_P = pmofsm_pkg::LONG_PRESS_TICKS
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic en_pin_in,
    input wire logic standby_request_pin_in,
    input wire logic thermal_shutdown_in,
    input wire logic undervoltage_in,
    input wire pmofsm_pkg::pmofsm_cfg_s cfg_in,
    input wire logic irq_pending_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output pmofsm_pkg::pmofsm_state_e state_out,
    output logic power_on_reset_out_n,
    output logic interrupt_out_n,
    output pmofsm_pkg::pmofsm_rail_s [pmofsm_pkg::NUM_BUCK-1:0] buck_out,
    output logic linear1_retention_out,
    output logic linear3_retention_out,
    output logic low_power_retention_mode_out
);
    localparam int NB = pmofsm_pkg::NUM_BUCK;
    localparam int SW = 4 + $bits(pmofsm_pkg::pmofsm_cfg_s);

    // Pins and comparator flags cross in through two flops
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic en_s;
    logic standby_request_pin_s;
    logic therm_s;
    logic uv_s;
    pmofsm_pkg::pmofsm_cfg_s cfg_s;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {en_pin_in, standby_request_pin_in,
                thermal_shutdown_in, undervoltage_in, cfg_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign {en_s, standby_request_pin_s, therm_s, uv_s, cfg_s} = sync2_reg;

    // Slow tick derived from the core clock
    logic [pmofsm_pkg::TICK_W-1:0] div_reg;
    logic tick_reg;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else if (div_reg ==
                pmofsm_pkg::TICK_W'(TICK_DIV_P - 1)) begin
            div_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // Power control register and set points
    logic standby_request_pin_inv_reg;
    logic [1:0] standby_request_pin_dly_reg;
    logic [7:0] on_sp_reg [NB];
    logic [7:0] standby_request_pin_sp_reg [NB];
    logic [7:0] slp_sp_reg [NB];

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            standby_request_pin_inv_reg <= pmofsm_pkg::STANDBY_POLARITY_INVERT_RST;
            standby_request_pin_dly_reg <= pmofsm_pkg::STANDBY_HOLD_OFF_DELAY_RST;
        end else if (reg_wr_in &&
                reg_addr_in == pmofsm_pkg::PWRCTL_ADDR) begin
            standby_request_pin_inv_reg <= reg_wdata_in[pmofsm_pkg::STANDBY_POLARITY_INVERT_BIT];
            standby_request_pin_dly_reg <= reg_wdata_in[pmofsm_pkg::STANDBY_HOLD_OFF_DELAY_MSB:
                pmofsm_pkg::STANDBY_HOLD_OFF_DELAY_LSB];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_sp
            // Standby bank starts as an image of the ON bank; the
            // host must set polarity before tailoring it
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    on_sp_reg[gi] <= pmofsm_pkg::ONSP_RST;
                    standby_request_pin_sp_reg[gi] <= pmofsm_pkg::ONSP_RST;
                    slp_sp_reg[gi] <= pmofsm_pkg::SLPSP_RST;
                end else if (reg_wr_in) begin
                    if (reg_addr_in == pmofsm_pkg::ONSP_ADDR + 8'(gi)) begin
                        on_sp_reg[gi] <= reg_wdata_in;
                    end
                    if (reg_addr_in ==
                            pmofsm_pkg::STBYSP_ADDR + 8'(gi)) begin
                        standby_request_pin_sp_reg[gi] <= reg_wdata_in;
                    end
                    if (reg_addr_in ==
                            pmofsm_pkg::SLPSP_ADDR + 8'(gi)) begin
                        slp_sp_reg[gi] <= reg_wdata_in;
                    end
                end
            end
        end
    endgenerate

    // Standby qualification
    logic standby_request_pin_ctl;

    pmofsm_standby_request_pin_qual u_standby_request_pin_qual (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .tick_in(tick_reg),
        .pin_in(standby_request_pin_s),
        .invert_in(standby_request_pin_inv_reg),
        .delay_in(standby_request_pin_dly_reg),
        .standby_request_pin_ctl_out(standby_request_pin_ctl)
    );

    // Enable press timing, sampled on the slow tick
    logic [pmofsm_pkg::LONG_W-1:0] low_cnt_reg;
    logic en_prev_reg;
    logic long_hit;
    logic short_rel;

    assign long_hit = (low_cnt_reg ==
        pmofsm_pkg::LONG_W'(LONG_TICKS_P));
    // Release after a long press is not a turn-on
    assign short_rel = tick_reg && en_s && !en_prev_reg &&
        (low_cnt_reg != '0) && !long_hit;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_cnt_reg <= '0;
            en_prev_reg <= 1'b0;
        end else if (tick_reg) begin
            en_prev_reg <= en_s;
            if (en_s && en_prev_reg) begin
                low_cnt_reg <= '0;
            end else if (!en_s && !long_hit) begin
                low_cnt_reg <= low_cnt_reg + 1'b1;
            end
        end
    end

    // Mode state machine
    pmofsm_pkg::pmofsm_state_e state_reg;
    pmofsm_pkg::pmofsm_state_e state_next;
    logic restart_reg;
    logic restart_next;
    logic any_sleep;
    logic turn_on;
    logic off_req;

    assign any_sleep = |cfg_s.regulator_sleep_mode_bit;
    assign turn_on = cfg_s.en_cfg ? short_rel : en_s;
    assign off_req = cfg_s.en_cfg ?
        (long_hit && cfg_s.long_press_off_enable) : !en_s;

    always_comb begin
        state_next = state_reg;
        restart_next = restart_reg;
        if (tick_reg) begin
            unique case (state_reg)
                pmofsm_pkg::ST_COIN: begin
                    // No turn-on accepted here
                    if (!uv_s) begin
                        state_next = pmofsm_pkg::ST_OFF;
                    end
                end
                pmofsm_pkg::ST_OFF: begin
                    if (uv_s) begin
                        state_next = pmofsm_pkg::ST_COIN;
                    end else if (!therm_s &&
                            (turn_on || restart_reg)) begin
                        state_next = pmofsm_pkg::ST_ON;
                        restart_next = 1'b0;
                    end
                end
                pmofsm_pkg::ST_ON,
                pmofsm_pkg::ST_STANDBY_REQUEST_PIN: begin
                    if (uv_s) begin
                        state_next = pmofsm_pkg::ST_COIN;
                    end else if (therm_s) begin
                        state_next = pmofsm_pkg::ST_OFF;
                    end else if (off_req && any_sleep) begin
                        state_next = pmofsm_pkg::ST_SLEEP;
                    end else if (off_req) begin
                        state_next = pmofsm_pkg::ST_OFF;
                        restart_next = cfg_s.auto_restart_enable;
                    end else if (state_reg == pmofsm_pkg::ST_ON) begin
                        if (standby_request_pin_ctl) begin
                            state_next = pmofsm_pkg::ST_STANDBY_REQUEST_PIN;
                        end
                    end else if (!standby_request_pin_ctl) begin
                        state_next = pmofsm_pkg::ST_ON;
                    end
                end
                pmofsm_pkg::ST_SLEEP: begin
                    if (uv_s) begin
                        state_next = pmofsm_pkg::ST_COIN;
                    end else if (therm_s) begin
                        state_next = pmofsm_pkg::ST_OFF;
                    end else if (turn_on) begin
                        state_next = pmofsm_pkg::ST_ON;
                    end
                end
                default: begin
                    state_next = pmofsm_pkg::ST_COIN;
                end
            endcase
        end
    end

    // Reset starts in coin cell until input is seen valid
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= pmofsm_pkg::ST_COIN;
            restart_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            restart_reg <= restart_next;
        end
    end

    // Status and reset outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_out <= pmofsm_pkg::ST_COIN;
            power_on_reset_out_n <= 1'b0;
        end else begin
            state_out <= state_reg;
            power_on_reset_out_n <= !(state_reg == pmofsm_pkg::ST_OFF ||
                state_reg == pmofsm_pkg::ST_COIN);
        end
    end

    // Interrupt pin is only live in powered states
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= !(irq_pending_in &&
                (state_reg == pmofsm_pkg::ST_ON ||
                 state_reg == pmofsm_pkg::ST_STANDBY_REQUEST_PIN ||
                 state_reg == pmofsm_pkg::ST_SLEEP));
        end
    end

    // Regulator control per buck
    generate
        for (gi = 0; gi < NB; gi++) begin : g_rail
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    buck_out[gi] <= '0;
                end else begin
                    unique case (state_reg)
                        pmofsm_pkg::ST_ON: begin
                            buck_out[gi] <= '{1'b1, 1'b0, on_sp_reg[gi]};
                        end
                        pmofsm_pkg::ST_STANDBY_REQUEST_PIN: begin
                            buck_out[gi] <= '{1'b1, 1'b0, standby_request_pin_sp_reg[gi]};
                        end
                        pmofsm_pkg::ST_SLEEP: begin
                            buck_out[gi] <= '{
                                cfg_s.regulator_sleep_mode_bit[gi],
                                1'b1, slp_sp_reg[gi]};
                        end
                        default: begin
                            buck_out[gi] <= '0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Retention rails in Sleep
    logic retain;

    assign retain = (state_reg == pmofsm_pkg::ST_SLEEP) &&
        cfg_s.linear1_sleep_mode_bit && cfg_s.linear3_sleep_mode_bit;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            linear1_retention_out <= 1'b0;
            linear3_retention_out <= 1'b0;
            low_power_retention_mode_out <= 1'b0;
        end else begin
            linear1_retention_out <= retain;
            linear3_retention_out <= retain;
            low_power_retention_mode_out <= retain;
        end
    end

    // Register read data, one cycle after the address
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_in == pmofsm_pkg::PWRCTL_ADDR) begin
            rd_mux[pmofsm_pkg::STANDBY_POLARITY_INVERT_BIT] = standby_request_pin_inv_reg;
            rd_mux[pmofsm_pkg::STANDBY_HOLD_OFF_DELAY_MSB:pmofsm_pkg::STANDBY_HOLD_OFF_DELAY_LSB] =
                standby_request_pin_dly_reg;
        end else if (reg_addr_in == pmofsm_pkg::STATUS_ADDR) begin
            rd_mux = {5'h00, state_reg};
        end
        for (int i = 0; i < NB; i++) begin
            if (reg_addr_in == pmofsm_pkg::ONSP_ADDR + 8'(i)) begin
                rd_mux = on_sp_reg[i];
            end
            if (reg_addr_in == pmofsm_pkg::STBYSP_ADDR + 8'(i)) begin
                rd_mux = standby_request_pin_sp_reg[i];
            end
            if (reg_addr_in == pmofsm_pkg::SLPSP_ADDR + 8'(i)) begin
                rd_mux = slp_sp_reg[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= rd_mux;
        end
    end
endmodule : pmofsm_top

// >>> test/pmofsm_top_chk.sv
`timescale 1ns/100ps
module pmofsm_top_chk #(
    parameter int TICK_DIV_P = 4,
    parameter int LONG_TICKS_P = 8
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic irq_pending_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire pmofsm_pkg::pmofsm_state_e state_out,
    input wire logic power_on_reset_out_n,
    input wire logic interrupt_out_n,
    input wire pmofsm_pkg::pmofsm_rail_s [pmofsm_pkg::NUM_BUCK-1:0] buck_out,
    input wire logic linear1_retention_out,
    input wire logic linear3_retention_out,
    input wire logic low_power_retention_mode_out
);
    int since_reg;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // Starts saturated so the first move out of reset is not misread
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            since_reg <= TICK_DIV_P;
        end else if ($changed(state_out)) begin
            since_reg <= 0;
        end else if (since_reg < TICK_DIV_P) begin
            since_reg <= since_reg + 1;
        end
    end

    a_one_per_tick: assert property (
        $changed(state_out) |-> since_reg >= TICK_DIV_P - 1)
        else $error("state moved twice within one slow tick");
    a_por_low_off: assert property (
        state_out inside {pmofsm_pkg::ST_OFF, pmofsm_pkg::ST_COIN}
        |-> !power_on_reset_out_n) else $error("reset output high in off");
    a_por_high_on: assert property (
        state_out == pmofsm_pkg::ST_ON |-> power_on_reset_out_n)
        else $error("reset output low in on");
    a_coin_exit_off: assert property (
        state_out == pmofsm_pkg::ST_COIN |=>
        state_out inside {pmofsm_pkg::ST_COIN, pmofsm_pkg::ST_OFF})
        else $error("coin cell left for a state other than off");
    a_standby_request_pin_from_on: assert property (
        $changed(state_out) && state_out == pmofsm_pkg::ST_STANDBY_REQUEST_PIN
        |-> $past(state_out) == pmofsm_pkg::ST_ON)
        else $error("standby entered from a state other than on");
    a_sleep_pfm: assert property (
        state_out == pmofsm_pkg::ST_SLEEP |->
        buck_out[0].pfm && buck_out[1].pfm && buck_out[2].pfm)
        else $error("buck not in pfm during sleep");
    a_retain_sleep: assert property (
        low_power_retention_mode_out |-> state_out == pmofsm_pkg::ST_SLEEP
        && linear1_retention_out && linear3_retention_out)
        else $error("retention outputs disagree");
    a_int_quiet_off: assert property (
        state_out inside {pmofsm_pkg::ST_OFF, pmofsm_pkg::ST_COIN}
        |-> interrupt_out_n) else $error("interrupt low while off");
    a_int_sleep_live: assert property (
        state_out == pmofsm_pkg::ST_SLEEP && $past(irq_pending_in)
        |-> !interrupt_out_n)
        else $error("interrupt not reported in sleep");
    a_pwr_readback: assert property (
        reg_wr_in && reg_addr_in == 8'h1B ##1 reg_addr_in == 8'h1B
        |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h70))
        else $error("power control readback wrong");
endmodule : pmofsm_top_chk

bind pmofsm_top pmofsm_top_chk #(.TICK_DIV_P(TICK_DIV_P),
    .LONG_TICKS_P(LONG_TICKS_P)) u_chk (.clk_in(clk_in),
    .rstn_in(rstn_in), .irq_pending_in(irq_pending_in),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .state_out(state_out), .power_on_reset_out_n(power_on_reset_out_n),
    .interrupt_out_n(interrupt_out_n), .buck_out(buck_out),
    .linear1_retention_out(linear1_retention_out),
    .linear3_retention_out(linear3_retention_out),
    .low_power_retention_mode_out(low_power_retention_mode_out));

// >>> test/pmofsm_host_model.sv
`timescale 1ns/100ps
module pmofsm_host_model (
    input wire logic clk_in,
    input wire logic en_req_in,
    input wire logic standby_request_pin_req_in,
    input wire logic invert_in,
    output logic en_pin_out = 1'b0,
    output logic standby_request_pin_pin_out = 1'b0
);
    // Board logic moves the pins a little after its own clock edge
    always @(posedge clk_in) begin
        en_pin_out <= #1 en_req_in;
        standby_request_pin_pin_out <= #1 standby_request_pin_req_in ^ invert_in;
    end
endmodule : pmofsm_host_model

// >>> test/test_pmic_operating_mode_fsm.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    n_errors++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
    $time, got, exp); end end
module test_pmic_operating_mode_fsm;
    localparam int TD = 4;
    localparam int LT = 8;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic en_req = 1'b0, standby_request_pin_req = 1'b0, inv = 1'b0, en_pin, standby_request_pin_pin;
    logic thermal = 1'b0, uv = 1'b1, irq = 1'b0, wr = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic por_n, int_n, lr1, lr3, low_power_retention_mode;
    logic [31:0] seed = 32'h26;
    pmofsm_pkg::pmofsm_cfg_s cfg = '0;
    pmofsm_pkg::pmofsm_state_e st;
    pmofsm_pkg::pmofsm_rail_s [2:0] buck;
    int n_errors = 0, compares = 0, cnt;

    always #2 clk_in = ~clk_in;

    pmofsm_top #(.TICK_DIV_P(TD), .LONG_TICKS_P(LT)) dut (.clk_in(clk_in),
        .rstn_in(rstn_in), .en_pin_in(en_pin),
        .standby_request_pin_in(standby_request_pin_pin), .thermal_shutdown_in(thermal),
        .undervoltage_in(uv), .cfg_in(cfg), .irq_pending_in(irq),
        .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .state_out(st), .power_on_reset_out_n(por_n),
        .interrupt_out_n(int_n), .buck_out(buck),
        .linear1_retention_out(lr1), .linear3_retention_out(lr3),
        .low_power_retention_mode_out(low_power_retention_mode));
    pmofsm_host_model host (.clk_in(clk_in), .en_req_in(en_req),
        .standby_request_pin_req_in(standby_request_pin_req), .invert_in(inv), .en_pin_out(en_pin),
        .standby_request_pin_pin_out(standby_request_pin_pin));

    function automatic logic [7:0] pwr_exp(input logic i, input logic [1:0] d);
        return {1'b0, i, d, 4'h0};
    endfunction : pwr_exp
    task next_rnd;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        v = seed[7:0];
    endtask : next_rnd
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask : wr_reg
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        cyc(2);
        `CHK(rdata, e)
    endtask : rd_chk
    // Bounded poll; cnt tells the caller how long the move took
    task wait_st(input pmofsm_pkg::pmofsm_state_e e);
        cnt = 0;
        while (st !== e && cnt < 600) begin
            cyc(1);
            cnt++;
        end
        `CHK(st, e)
    endtask : wait_st
    task hold_st(input pmofsm_pkg::pmofsm_state_e e);
        cyc(10 * TD);
        `CHK(st, e)
    endtask : hold_st
    task print_verdict;
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #100000;
        n_errors++;
        print_verdict;
    end

    initial begin
        cyc(4);
        rstn_in = 1'b1;
        `CHK(por_n, 1'b0)
        en_req = 1'b1;
        hold_st(pmofsm_pkg::ST_COIN);
        uv = 1'b0;
        wait_st(pmofsm_pkg::ST_ON);
        `CHK(por_n, 1'b1)
        rd_chk(8'h28, 8'h10);
        rd_chk(8'h1B, pwr_exp(1'b0, 2'h1));
        rd_chk(8'h40, 8'h00);
        rd_chk(8'h1C, {5'h00, pmofsm_pkg::ST_ON});
        for (int d = 0; d < 4; d++) begin
            // Polarity goes first, then the standby set point
            inv = d[0];
            wr_reg(8'h1B, pwr_exp(inv, d[1:0]));
            rd_chk(8'h1B, pwr_exp(inv, d[1:0]));
            next_rnd;
            wr_reg(8'h28, v);
            standby_request_pin_req = 1'b1;
            wait_st(pmofsm_pkg::ST_STANDBY_REQUEST_PIN);
            `CHK(cnt >= (3 + d) * TD, 1'b1)
            `CHK(cnt <= (4 + d) * TD + 4, 1'b1)
            `CHK(buck[0].vsel, v)
            standby_request_pin_req = 1'b0;
            wait_st(pmofsm_pkg::ST_ON);
        end
        thermal = 1'b1;
        wait_st(pmofsm_pkg::ST_OFF);
        standby_request_pin_req = 1'b1;
        hold_st(pmofsm_pkg::ST_OFF);
        standby_request_pin_req = 1'b0;
        thermal = 1'b0;
        wait_st(pmofsm_pkg::ST_ON);
        next_rnd;
        cfg.regulator_sleep_mode_bit = seed[10:8] | 3'h1;
        cfg.linear1_sleep_mode_bit = 1'b1;
        cfg.linear3_sleep_mode_bit = 1'b1;
        irq = 1'b1;
        wr_reg(8'h30, v);
        en_req = 1'b0;
        wait_st(pmofsm_pkg::ST_SLEEP);
        cyc(2);
        `CHK(buck[0].vsel, v)
        `CHK({buck[2].en, buck[1].en, buck[0].en}, seed[10:8] | 3'h1)
        `CHK(low_power_retention_mode & lr1 & lr3, 1'b1)
        `CHK(int_n, 1'b0)
        en_req = 1'b1;
        wait_st(pmofsm_pkg::ST_ON);
        irq = 1'b0;
        cfg = '0;
        cyc(4);
        en_req = 1'b0;
        wait_st(pmofsm_pkg::ST_OFF);
        `CHK(por_n, 1'b0)
        cfg.en_cfg = 1'b1;
        cfg.long_press_off_enable = 1'b1;
        // Low past the long-press limit: that release is no turn-on
        cyc((LT + 2) * TD);
        en_req = 1'b1;
        hold_st(pmofsm_pkg::ST_OFF);
        en_req = 1'b0;
        cyc(2 * TD);
        en_req = 1'b1;
        wait_st(pmofsm_pkg::ST_ON);
        cfg.auto_restart_enable = 1'b1;
        en_req = 1'b0;
        wait_st(pmofsm_pkg::ST_OFF);
        `CHK(cnt >= LT * TD, 1'b1)
        wait_st(pmofsm_pkg::ST_ON);
        en_req = 1'b1;
        uv = 1'b1;
        wait_st(pmofsm_pkg::ST_COIN);
        hold_st(pmofsm_pkg::ST_COIN);
        // Full depletion reset: every register back to its default
        rstn_in = 1'b0;
        cyc(4);
        rstn_in = 1'b1;
        rd_chk(8'h1B, pwr_exp(1'b0, 2'h1));
        rd_chk(8'h28, 8'h10);
        rd_chk(8'h30, 8'h08);
        print_verdict;
    end
endmodule : test_pmic_operating_mode_fsm
